// >>> bsm_pkg.sv
// Purpose: Shared constants and types for the strap and secondary clock mask block.
// Assumes: Configuration space is reached by byte offset on an internal access port.
// Notes:   Offsets are byte addresses; reads and writes are whole 32-bit words.
package bsm_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int CLK_OUT_N = 10;
  localparam int GPIO_N    = 4;
  localparam int IR_W      = 4;

  // ---------------------------------------------------------------------------
  // Configuration offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CMD_STAT  = 8'h04;
  localparam logic [7:0] OFS_PM_CAP    = 8'hDE;
  localparam logic [7:0] OFS_GPIO      = 8'h60;
  localparam logic [7:0] OFS_SCLK_MASK = 8'h68;
  localparam logic [7:0] OFS_PM_CSR    = 8'hE0;

  // ---------------------------------------------------------------------------
  // Field positions and values
  // ---------------------------------------------------------------------------
  localparam int STAT_66_BIT  = 21;
  localparam int PM_WAKE_LSB  = 27;
  localparam int GPIO_OUT_LSB = 0;
  localparam int GPIO_OE_LSB  = 4;
  localparam int GPIO_IN_LSB  = 8;
  localparam int FEEDBACK_BIT = 31;
  localparam logic [4:0]  WAKE_ALL   = 5'h1F;
  localparam logic [4:0]  WAKE_NONE  = 5'h00;
  localparam logic [1:0]  PWR_D2     = 2'h2;
  localparam logic [1:0]  PWR_D3HOT  = 2'h3;
  localparam logic [1:0]  PWR_RST    = 2'h0;
  localparam logic [15:0] CMD_RST    = 16'h0000;
  localparam logic [3:0]  IR_BYPASS  = 4'hF;
  localparam logic [3:0]  IR_IDCODE  = 4'h1;
  localparam logic [3:0]  IR_CAPTURE = 4'h1;
  // Arbitrary identification value; bit 0 must stay set.
  localparam logic [31:0] IDCODE_DEF = 32'h0A5A_0001;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LD_IDLE  = 2'b00,
    LD_SHIFT = 2'b01,
    LD_DONE  = 2'b10
  } bsm_load_e;

  typedef enum logic [3:0] {
    TS_RESET  = 4'b0000, TS_IDLE   = 4'b0001, TS_SEL_DR = 4'b0010, TS_CAP_DR = 4'b0011,
    TS_SH_DR  = 4'b0100, TS_EX1_DR = 4'b0101, TS_PA_DR  = 4'b0110, TS_EX2_DR = 4'b0111,
    TS_UP_DR  = 4'b1000, TS_SEL_IR = 4'b1001, TS_CAP_IR = 4'b1010, TS_SH_IR  = 4'b1011,
    TS_EX1_IR = 4'b1100, TS_PA_IR  = 4'b1101, TS_EX2_IR = 4'b1110, TS_UP_IR  = 4'b1111
  } bsm_tap_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bsm_cfg_req_s;

endpackage

// >>> bsm_tap.sv
// Purpose: Boundary-scan test access port controller with instruction and data paths.
// Assumes: TCK is slow against CLK and synchronous to it, so it is sampled as data.
// Notes:   Only bypass and identification registers are behind the port.
`timescale 1ns/100ps
module bsm_tap
  import bsm_pkg::*;
#(
  parameter logic [31:0] IDCODE = IDCODE_DEF
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic trst_n,
  output logic      tdo,
  output logic      tdo_en
);

  bsm_tap_e         st_q;
  bsm_tap_e         st_d;
  logic             tck_q;
  logic [IR_W-1:0]  ir_q;
  logic [IR_W-1:0]  irsh_q;
  logic [31:0]      dr_q;

  // ---------------------------------------------------------------------------
  // Test clock edges
  // ---------------------------------------------------------------------------
  wire tck_rise = tck & ~tck_q;
  wire tck_fall = ~tck & tck_q;
  wire tap_init = rst | ~trst_n;
  wire is_byp   = (ir_q != IR_IDCODE);
  wire shift_dr = (st_q == TS_SH_DR);
  wire shift_ir = (st_q == TS_SH_IR);
  wire shift_bit = shift_ir ? irsh_q[0] : dr_q[0];

  // Controller walk, one step per rising test clock.
  always_comb
  begin
    case (st_q)                                            // see [RULE10]
      TS_RESET:  st_d = tms ? TS_RESET  : TS_IDLE;
      TS_IDLE:   st_d = tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: st_d = tms ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: st_d = tms ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR:  st_d = tms ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: st_d = tms ? TS_UP_DR  : TS_PA_DR;
      TS_PA_DR:  st_d = tms ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: st_d = tms ? TS_UP_DR  : TS_SH_DR;
      TS_UP_DR:  st_d = tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: st_d = tms ? TS_RESET  : TS_CAP_IR;
      TS_CAP_IR: st_d = tms ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR:  st_d = tms ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: st_d = tms ? TS_UP_IR  : TS_PA_IR;
      TS_PA_IR:  st_d = tms ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: st_d = tms ? TS_UP_IR  : TS_SH_IR;
      TS_UP_IR:  st_d = tms ? TS_SEL_DR : TS_IDLE;
      default:   st_d = TS_RESET;
    endcase
  end

  // State, instruction and data registers move on the rising test clock.
  always_ff @(posedge clk)
  begin
    tck_q <= tck;
    if (tap_init)
    begin
      st_q <= TS_RESET;                                    // see [RULE9]
      ir_q <= IR_IDCODE;
    end
    else if (tck_rise)
    begin
      st_q <= st_d;
      if (st_q == TS_RESET)  ir_q <= IR_IDCODE;
      if (st_q == TS_UP_IR)  ir_q <= irsh_q;
      if (st_q == TS_CAP_IR) irsh_q <= IR_CAPTURE;
      if (shift_ir)          irsh_q <= {tdi, irsh_q[IR_W-1:1]};   // see [RULE11]
      if (st_q == TS_CAP_DR) dr_q <= is_byp ? 32'h0000_0000 : IDCODE;
      if (shift_dr)          dr_q <= is_byp ? {31'h0000_0000, tdi} : {tdi, dr_q[31:1]};
    end
  end

  // Output changes on the falling test clock so the tester samples a stable bit.
  always_ff @(posedge clk)
  begin
    if (tap_init)
    begin
      tdo    <= 1'b0;
      tdo_en <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo    <= (shift_dr | shift_ir) & shift_bit;         // see [RULE11]
      tdo_en <= shift_dr | shift_ir;
    end
  end

endmodule

// >>> bsm_strap_clock_mask.sv
// Purpose: Strap capture, secondary clock disable mask, clock gating, GPIO and test port.
// Assumes: CLK is the primary bus clock at 25 MHz; RST is primary reset, synchronous.
// Notes:   Configuration reads answer on CFG_RDATA one cycle after the read strobe.
//
// Notes on behaviour
// [RULE1] Mask stream loads after primary reset releases while secondary reset is held.
// [RULE2] Each mask bit shifts into the clock mask register; set bits disable clocks.
// [RULE3] Mask input low keeps all clocks running; high drives all clock outputs high.
// [RULE4] Strap high and D2 or D3hot: secondary bus in B2, clocks driven low.
// [RULE5] Strap low: D2 or D3hot leaves the secondary clocks unaffected.
// [RULE6] Fast clock strap high sets status bit 21 of the dword at offset 04h.
// [RULE7] Wake strap low presets capability bits 31:27 at DEh to ones, high to zeros.
// [RULE8] Four general-purpose pins, each input-only or bidirectional by an enable register.
// [RULE9] Active-low test reset forces the test port controller to its initial state.
// [RULE10] Test mode select steers the controller, sampled on the test clock.
// [RULE11] Instructions and data shift in on TDI and out on TDO, timed by TCK.
// [RULE12] Clock outputs are phase synchronous to CLK; one feeds back to the input.
// [RULE13] Fast clock strap low makes status bit 21 at offset 04h read zero.
`timescale 1ns/100ps
module bsm_strap_clock_mask
  import bsm_pkg::*;
#(
  parameter int CLK_N  = CLK_OUT_N,
  parameter int GPIO_W = GPIO_N
)
(
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire bsm_pkg::bsm_cfg_req_s CFG_REQ,
  output logic [31:0]                CFG_RDATA,
  input  wire logic                  CLOCK_MASK_SERIAL_IN,
  input  wire logic                  BUS_POWER_CLOCK_CTRL_STRAP,
  input  wire logic                  FAST_CLOCK_CAPABLE_STRAP,
  input  wire logic                  WAKE_SUPPORT_STRAP_N,
  output logic [CLK_N-1:0]           SECONDARY_CLOCK_OUTPUTS,
  input  wire logic                  SECONDARY_CLOCK_FEEDBACK,
  output logic                       SEC_RESET_N,
  output logic                       SEC_BUS_B2,
  input  wire logic [GPIO_W-1:0]     GPIO_IN,
  output logic [GPIO_W-1:0]          GPIO_OUT,
  output logic [GPIO_W-1:0]          GPIO_OE,
  input  wire logic                  TCK,
  input  wire logic                  TMS,
  input  wire logic                  TDI,
  input  wire logic                  TRST_N,
  output logic                       TDO,
  output logic                       TDO_EN
);

  localparam int CNT_W = $clog2(CLK_N);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CLK_N - 1);

  bsm_load_e         ld_q;
  bsm_load_e         ld_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CLK_N-1:0]  mask_q;
  logic [CLK_N-1:0]  mask_d;
  logic [CLK_N-1:0]  clk_d;
  logic              div_q;
  logic              fast_q;
  logic              wake_n_q;
  logic              bpcc_q;
  logic              fb_q;
  logic [15:0]       cmd_q;
  logic [1:0]        pwr_q;
  logic [GPIO_W-1:0] gin_q;

  // ---------------------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------------------
  // Decoding is plain address compare; unmapped offsets read as zero.
  wire hit_cmd  = (CFG_REQ.addr == OFS_CMD_STAT);
  wire hit_pmc  = (CFG_REQ.addr == OFS_PM_CAP);
  wire hit_gpio = (CFG_REQ.addr == OFS_GPIO);
  wire hit_mask = (CFG_REQ.addr == OFS_SCLK_MASK);
  wire hit_pcsr = (CFG_REQ.addr == OFS_PM_CSR);
  wire wr_cmd   = CFG_REQ.wr & hit_cmd;
  wire wr_gpio  = CFG_REQ.wr & hit_gpio;
  wire wr_mask  = CFG_REQ.wr & hit_mask;
  wire wr_pcsr  = CFG_REQ.wr & hit_pcsr;

  // Status bit 21 follows the captured strap alone, so a low strap reads zero.
  wire [31:0] rd_cmd  = {16'h0000, cmd_q} | (32'(fast_q) << STAT_66_BIT);  // see [RULE6] [RULE13]
  wire [4:0]  wake_f  = wake_n_q ? WAKE_NONE : WAKE_ALL;                    // see [RULE7]
  wire [31:0] rd_pmc  = 32'(wake_f) << PM_WAKE_LSB;
  wire [31:0] rd_gpio = (32'(GPIO_OUT) << GPIO_OUT_LSB) | (32'(GPIO_OE) << GPIO_OE_LSB)
                      | (32'(gin_q) << GPIO_IN_LSB);
  wire [31:0] rd_mask = (32'(fb_q) << FEEDBACK_BIT) | 32'(mask_q);
  wire [31:0] rd_pcsr = 32'(pwr_q);
  wire [31:0] rd_mux  = hit_cmd  ? rd_cmd  :
                        hit_pmc  ? rd_pmc  :
                        hit_gpio ? rd_gpio :
                        hit_mask ? rd_mask :
                        hit_pcsr ? rd_pcsr : 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Power state and clock gating
  // ---------------------------------------------------------------------------
  // B2 needs both the strap and a deep power state; with the strap low the
  // power state has no hold on the clocks at all.
  wire low_pwr = (pwr_q == PWR_D2) | (pwr_q == PWR_D3HOT);
  wire b2_d    = bpcc_q & low_pwr;                                          // see [RULE4] [RULE5]

  // Per-output gate: B2 forces low, a mask bit parks the output high.
  genvar gi;
  generate
    for (gi = 0; gi < CLK_N; gi = gi + 1)
    begin : g_clk
      always_comb
      begin
        if (b2_d)
          clk_d[gi] = 1'b0;                                                 // see [RULE4]
        else if (mask_q[gi])
          clk_d[gi] = 1'b1;                                                 // see [RULE2] [RULE3]
        else
          clk_d[gi] = ~div_q;                                               // see [RULE12]
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Serial mask loader
  // ---------------------------------------------------------------------------
  // One mask bit per clock while the secondary reset is still held; the first
  // bit received ends up in mask bit 0.
  always_comb
  begin
    ld_d   = ld_q;
    mask_d = mask_q;
    case (ld_q)
      LD_IDLE:
      begin
        if (!SEC_RESET_N)
          ld_d = LD_SHIFT;                                                  // see [RULE1]
      end
      LD_SHIFT:
      begin
        mask_d = {CLOCK_MASK_SERIAL_IN, mask_q[CLK_N-1:1]};                 // see [RULE2]
        if (cnt_q == CNT_LAST)
          ld_d = LD_DONE;
      end
      LD_DONE:
      begin
        if (wr_mask)
          mask_d = CFG_REQ.wdata[CLK_N-1:0];
      end
      default:
      begin
        ld_d = LD_IDLE;
      end
    endcase
  end

  // Loader state, counter and the secondary reset it holds.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ld_q        <= LD_IDLE;
      cnt_q       <= '0;
      mask_q      <= '0;
      SEC_RESET_N <= 1'b0;
    end
    else
    begin
      ld_q        <= ld_d;
      mask_q      <= mask_d;
      cnt_q       <= (ld_q == LD_SHIFT) ? cnt_q + 1'b1 : '0;
      SEC_RESET_N <= (ld_d == LD_DONE);                                     // see [RULE1]
    end
  end

  // ---------------------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------------------
  // Straps are caught in the first cycle after reset release, not during
  // reset, so a strap that settles late in reset is still seen.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      fast_q   <= 1'b0;
      wake_n_q <= 1'b1;
      bpcc_q   <= 1'b0;
    end
    else if (ld_q == LD_IDLE)
    begin
      fast_q   <= FAST_CLOCK_CAPABLE_STRAP;                                 // see [RULE6]
      wake_n_q <= WAKE_SUPPORT_STRAP_N;                                     // see [RULE7]
      bpcc_q   <= BUS_POWER_CLOCK_CTRL_STRAP;
    end
  end

  // ---------------------------------------------------------------------------
  // Writable configuration state
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cmd_q    <= CMD_RST;
      pwr_q    <= PWR_RST;
      GPIO_OUT <= '0;
      GPIO_OE  <= '0;
    end
    else
    begin
      if (wr_cmd)
        cmd_q <= CFG_REQ.wdata[15:0];
      if (wr_pcsr)
        pwr_q <= CFG_REQ.wdata[1:0];
      if (wr_gpio)
      begin
        GPIO_OUT <= CFG_REQ.wdata[GPIO_OUT_LSB +: GPIO_W];
        GPIO_OE  <= CFG_REQ.wdata[GPIO_OE_LSB +: GPIO_W];                   // see [RULE8]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Clock outputs, sampled inputs and read data
  // ---------------------------------------------------------------------------
  // The divider gives secondary clocks at half CLK, edge aligned with it; a
  // true full-rate copy would need a clock gate outside this logic.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      div_q                   <= 1'b0;
      SECONDARY_CLOCK_OUTPUTS <= '0;
      SEC_BUS_B2              <= 1'b0;
      fb_q                    <= 1'b0;
      gin_q                   <= '0;
      CFG_RDATA               <= 32'h0000_0000;
    end
    else
    begin
      div_q                   <= ~div_q;
      SECONDARY_CLOCK_OUTPUTS <= clk_d;                                     // see [RULE12]
      SEC_BUS_B2              <= b2_d;                                      // see [RULE4]
      fb_q                    <= SECONDARY_CLOCK_FEEDBACK;
      gin_q                   <= GPIO_IN;
      CFG_RDATA               <= CFG_REQ.rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Test access port
  // ---------------------------------------------------------------------------
  bsm_tap #(
    .IDCODE (IDCODE_DEF)
  ) bsm_tap_i (
    .clk    (CLK),
    .rst    (RST),
    .tck    (TCK),
    .tms    (TMS),
    .tdi    (TDI),
    .trst_n (TRST_N),
    .tdo    (TDO),
    .tdo_en (TDO_EN)
  );

endmodule

// >>> bsm_mask_source.sv
// Purpose: Board-side model of the serial clock mask source and clock feedback.
// Assumes: One mask bit per CLK; the first is sampled two edges after reset release.
// Notes:   Outside the load window the line toggles unless told to stay steady.
`timescale 1ns/100ps
module bsm_mask_source
  import bsm_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [CLK_OUT_N-1:0] pattern,
  input  wire logic                 steady,
  input  wire logic [CLK_OUT_N-1:0] clk_outs,
  output logic                      mask_bit,
  output logic                      feedback
);
  int unsigned cnt = 0;
  initial mask_bit = 1'b0;
  // Bit k is shown after edge k+1; toggling elsewhere exposes a loader
  // that samples outside its window.
  always @(posedge clk)
  begin
    cnt = rst ? 0 : cnt + 1;
    #1;
    if (cnt >= 1 && cnt < 1 + CLK_OUT_N)
      mask_bit = pattern[cnt - 1];
    else
      mask_bit = steady ? pattern[0] : ~mask_bit;
  end
  // One clock output is looped back as the secondary clock input.
  assign feedback = clk_outs[0];
endmodule

// >>> bsm_strap_clock_mask_asserts.sv
// Purpose: Port-level timing checks for the strap and clock mask block.
// Assumes: Straps stay steady while the block is out of reset.
// Notes:   Attached to the top module by the bind at the foot of this file.
`timescale 1ns/100ps
module bsm_sc_asserts
  import bsm_pkg::*;
#(
  parameter int CLK_N  = CLK_OUT_N,
  parameter int GPIO_W = GPIO_N
)
(
  input wire logic                  CLK,
  input wire logic                  RST,
  input wire bsm_pkg::bsm_cfg_req_s CFG_REQ,
  input wire logic [31:0]           CFG_RDATA,
  input wire logic                  BUS_POWER_CLOCK_CTRL_STRAP,
  input wire logic                  FAST_CLOCK_CAPABLE_STRAP,
  input wire logic                  WAKE_SUPPORT_STRAP_N,
  input wire logic [CLK_N-1:0]      SECONDARY_CLOCK_OUTPUTS,
  input wire logic                  SEC_RESET_N,
  input wire logic                  SEC_BUS_B2,
  input wire logic [GPIO_W-1:0]     GPIO_OUT,
  input wire logic [GPIO_W-1:0]     GPIO_OE,
  input wire logic                  TMS,
  input wire logic                  TRST_N,
  input wire logic                  TDO,
  input wire logic                  TDO_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // Mask load and secondary clocks
  // ----------------------------------------
  a_mask_load_time: assert property ($fell(RST) |->
    !SEC_RESET_N [*8] ##[1:8] SEC_RESET_N)
    else $error("secondary reset release out of window");
  a_clk_no_stall: assert property ((SEC_RESET_N && !SEC_BUS_B2) [*4] |->
    (SECONDARY_CLOCK_OUTPUTS | $past(SECONDARY_CLOCK_OUTPUTS)) == {CLK_N{1'b1}})
    else $error("secondary clock low for two cycles");
  a_b2_clocks_low: assert property (SEC_BUS_B2 && $past(SEC_BUS_B2) |->
    SECONDARY_CLOCK_OUTPUTS == '0)
    else $error("secondary clocks not low in B2");
  a_b2_cause: assert property ($rose(SEC_BUS_B2) |->
    BUS_POWER_CLOCK_CTRL_STRAP &&
    ($past(CFG_REQ.wr && CFG_REQ.addr == OFS_PM_CSR) ||
     $past(CFG_REQ.wr && CFG_REQ.addr == OFS_PM_CSR, 2)))
    else $error("B2 entered without strap and power write");
  a_strap_low_b2: assert property (!BUS_POWER_CLOCK_CTRL_STRAP |-> !SEC_BUS_B2)
    else $error("B2 entered with strap low");
  // ----------------------------------------
  // Strap bits, GPIO and test port
  // ----------------------------------------
  a_fast_bit: assert property (CFG_REQ.rd && CFG_REQ.addr == OFS_CMD_STAT |=>
    CFG_RDATA[STAT_66_BIT] == FAST_CLOCK_CAPABLE_STRAP)
    else $error("status bit 21 differs from strap");
  a_wake_bits: assert property (CFG_REQ.rd && CFG_REQ.addr == OFS_PM_CAP |=>
    CFG_RDATA[31:27] == (WAKE_SUPPORT_STRAP_N ? WAKE_NONE : WAKE_ALL))
    else $error("wake capability bits wrong");
  a_gpio_write: assert property (CFG_REQ.wr && CFG_REQ.addr == OFS_GPIO |=>
    GPIO_OE == $past(CFG_REQ.wdata[GPIO_OE_LSB +: GPIO_W]) &&
    GPIO_OUT == $past(CFG_REQ.wdata[GPIO_OUT_LSB +: GPIO_W]))
    else $error("GPIO registers not updated");
  a_tap_reset: assert property (!TRST_N ##1 !TRST_N |-> !TDO_EN && !TDO)
    else $error("test port output active in test reset");
  a_shift_entry: assert property ($rose(TDO_EN) |-> TRST_N && !$past(TMS))
    else $error("shift state entered without TMS low");
  c_load_done: cover property ($rose(SEC_RESET_N));
  c_b2_entry: cover property ($rose(SEC_BUS_B2));
  c_shift: cover property ($rose(TDO_EN));
endmodule

bind bsm_strap_clock_mask bsm_sc_asserts #(.CLK_N(CLK_N), .GPIO_W(GPIO_W)) bsm_sc_asserts_i (
  .CLK(CLK), .RST(RST), .CFG_REQ(CFG_REQ), .CFG_RDATA(CFG_RDATA),
  .BUS_POWER_CLOCK_CTRL_STRAP(BUS_POWER_CLOCK_CTRL_STRAP),
  .FAST_CLOCK_CAPABLE_STRAP(FAST_CLOCK_CAPABLE_STRAP),
  .WAKE_SUPPORT_STRAP_N(WAKE_SUPPORT_STRAP_N),
  .SECONDARY_CLOCK_OUTPUTS(SECONDARY_CLOCK_OUTPUTS), .SEC_RESET_N(SEC_RESET_N),
  .SEC_BUS_B2(SEC_BUS_B2), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE), .TMS(TMS),
  .TRST_N(TRST_N), .TDO(TDO), .TDO_EN(TDO_EN));

// >>> bsm_strap_clock_mask_bench.sv
// Purpose: Self-checking bench for the strap and clock mask block.
// Assumes: The mask stream comes from the partner model, one bit per clock.
// Notes:   Reads are judged by a monitor against a queue of expected words.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module bsm_strap_clock_mask_bench;
  import bsm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd_seen = 1'b0;
  bsm_cfg_req_s req = '0;
  logic bpcc = 1'b1, fast = 1'b1, wake_n = 1'b0, steady = 1'b0, mbit, fb, sec_rst_n, b2;
  logic tck = 1'b1, tms = 1'b1, tdi = 1'b0, trst_n = 1'b0, tdo, tdo_en, tdo_bit, en_bit;
  logic [CLK_OUT_N-1:0] pat = 10'h2D5, outs, o1;
  logic [GPIO_N-1:0] gin = 4'h0, gout, goe;
  logic [1:0] ps[2] = '{PWR_D2, PWR_D3HOT};
  logic [31:0] q_exp[$], q_msk[$], w, m_e, m_m, id, m_rd;
  string q_nm[$], m_n;
  int err_count = 0, n_compared = 0, seed = 32'h85EE57C8;

  always #20 clk = ~clk;

  bsm_strap_clock_mask bsm_strap_clock_mask_i (.CLK(clk), .RST(rst), .CFG_REQ(req),
    .CFG_RDATA(m_rd), .CLOCK_MASK_SERIAL_IN(mbit), .BUS_POWER_CLOCK_CTRL_STRAP(bpcc),
    .FAST_CLOCK_CAPABLE_STRAP(fast), .WAKE_SUPPORT_STRAP_N(wake_n),
    .SECONDARY_CLOCK_OUTPUTS(outs), .SECONDARY_CLOCK_FEEDBACK(fb), .SEC_RESET_N(sec_rst_n),
    .SEC_BUS_B2(b2), .GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE(goe), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TRST_N(trst_n), .TDO(tdo), .TDO_EN(tdo_en));
  bsm_mask_source bsm_mask_source_i (.clk(clk), .rst(rst), .pattern(pat), .steady(steady),
    .clk_outs(outs), .mask_bit(mbit), .feedback(fb));

  // Read data stands one cycle only, so it is taken at the edge after the strobe.
  always @(posedge clk)
  begin
    if (rd_seen)
    begin
      m_e = q_exp.pop_front();
      m_m = q_msk.pop_front();
      m_n = q_nm.pop_front();
      `CHK(m_n, m_e & m_m, m_rd & m_m);
    end
    rd_seen = req.rd;
  end

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic idle(int n);
    req = '0;
    cyc(n);
  endtask
  task automatic cfg(logic wr, logic [7:0] a, logic [31:0] d);
    req = '{wr: wr, rd: !wr, addr: a, wdata: d};
    cyc(1);
  endtask
  task automatic rd_exp(logic [7:0] a, logic [31:0] e, logic [31:0] m, string nm);
    q_exp.push_back(e);
    q_msk.push_back(m);
    q_nm.push_back(nm);
    cfg(1'b0, a, 32'h0);
  endtask
  // Masked clocks sit high, free ones toggle, and B2 holds all low.
  task automatic chk_clks(logic [CLK_OUT_N-1:0] m, logic in_b2);
    o1 = outs;
    cyc(1);
    `CHK("clk_and", in_b2 ? 10'h0 : m, o1 & outs);
    `CHK("clk_or", in_b2 ? 10'h0 : 10'h3FF, o1 | outs);
  endtask
  task automatic tck_step(logic m, logic d);
    tms = m;
    tdi = d;
    tck = 1'b0;
    cyc(3);
    tdo_bit = tdo;
    en_bit = tdo_en;
    tck = 1'b1;
    cyc(3);
  endtask
  // A full reset with one strap setting, then mask, strap bits and power states.
  task automatic run_cfg(logic bp, logic fa, logic wk, logic [CLK_OUT_N-1:0] p, logic st);
    rst = 1'b1;
    bpcc = bp;
    fast = fa;
    wake_n = wk;
    pat = p;
    steady = st;
    cyc(5);
    rst = 1'b0;
    cyc(16);
    `CHK("sec_reset_n", 1'b1, sec_rst_n);
    chk_clks(p, 1'b0);
    // A masked output 0 parks high, so the looped-back feedback bit reads one.
    rd_exp(OFS_SCLK_MASK, {p[0], 21'h0, p}, {p[0], 21'h0, 10'h3FF}, "mask_reg");
    rd_exp(OFS_CMD_STAT, {10'h0, fa, 21'h0}, 32'h0020_FFFF, "status");
    rd_exp(OFS_PM_CAP, {wk ? WAKE_NONE : WAKE_ALL, 27'h0}, 32'hF800_0000, "pm_cap");
    foreach (ps[i])
    begin
      cfg(1'b1, OFS_PM_CSR, {30'h0, ps[i]});
      idle(3);
      `CHK("b2", bp, b2);
      chk_clks(p, bp);
      cfg(1'b1, OFS_PM_CSR, {30'h0, PWR_RST});
      idle(3);
    end
    $display("test reset_config done");
  endtask

  initial
  begin
    run_cfg(1'b1, 1'b1, 1'b0, 10'h2D5, 1'b0);
    w = $random(seed);
    cfg(1'b1, OFS_CMD_STAT, w);
    rd_exp(OFS_CMD_STAT, {10'h0, 1'b1, 5'h0, w[15:0]}, 32'h0020_FFFF, "cmd");
    cfg(1'b1, OFS_PM_CAP, 32'h0);
    rd_exp(OFS_PM_CAP, 32'hF800_0000, 32'hF800_0000, "pm_cap_ro");
    rd_exp(8'h10, 32'h0, 32'hFFFF_FFFF, "unmapped");
    cfg(1'b1, OFS_SCLK_MASK, w);
    idle(3);
    chk_clks(w[9:0], 1'b0);
    gin = w[19:16];
    cfg(1'b1, OFS_GPIO, w);
    idle(3);
    `CHK("gpio_out", w[3:0], gout);
    `CHK("gpio_oe", w[7:4], goe);
    rd_exp(OFS_GPIO, {20'h0, w[19:16], w[7:0]}, 32'h0000_0FFF, "gpio_reg");
    idle(2);
    $display("test registers done");
    run_cfg(1'b0, 1'b0, 1'b1, 10'h000, 1'b1);
    run_cfg(1'b1, 1'b0, 1'b1, 10'h3FF, 1'b1);
    `CHK("tdo_en_reset", 1'b0, tdo_en);
    trst_n = 1'b1;
    tck_step(1'b0, 1'b0);
    tck_step(1'b1, 1'b0);
    tck_step(1'b0, 1'b0);
    tck_step(1'b0, 1'b0);
    for (int i = 0; i < 32; i++)
    begin
      tck_step(i == 31, 1'b0);
      id[i] = tdo_bit;
      `CHK("tdo_en_shift", 1'b1, en_bit);
    end
    tck_step(1'b1, 1'b0);
    tck_step(1'b0, 1'b0);
    `CHK("idcode", IDCODE_DEF, id);
    $display("test scan done");
    results();
  end

  // A hang is cut short well past the expected run of about 370 cycles.
  initial
  begin
    #200000;
    err_count++;
    results();
  end

  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
endmodule
